//--- rtl/rrs_pkg.sv
// Constants shared by the receive status register bank and its parts.
// Assumes the register port decodes a flat 8-bit address space.
package rrs_pkg;

    localparam int NUM_CHAN = 2;
    localparam int BYTE_BITS = 8;
    localparam int EOF_LEN_BITS = 3;
    localparam int BIT_POS_BITS = 3;

    localparam logic [7:0] ADDR_RX_IRQ_STATUS = 8'h08;
    localparam logic [7:0] ADDR_RX_BYTE_A = 8'h09;
    localparam logic [7:0] ADDR_RX_BITVALID_A = 8'h0a;

    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] ALL_BITS_VALID = 8'hff;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // Field positions inside receive_irq_status, channel A half
    localparam int STAT_FULL_POS = 0;
    localparam int STAT_EOF_POS = 1;
    localparam int STAT_FLOW_POS = 2;
    localparam int STAT_ALLVALID_POS = 3;
    // Channel B fields sit this far above their channel A twins
    localparam int STAT_CHAN_STRIDE = 4;

    // Symbol FIFO between the correlator and the byte assembler
    localparam int SYM_WIDTH = 2;
    localparam int SYM_DEPTH = 32;
    localparam int SYM_GOOD_POS = 1;
    localparam int SYM_BIT_POS = 0;

    localparam logic [BIT_POS_BITS-1:0] LAST_BIT_POS = 3'h7;

endpackage

//--- rtl/rrs_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module rrs_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 32
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PTR_BITS = $clog2(DEPTH);
    localparam int CNT_BITS = PTR_BITS + 1;
    localparam logic [CNT_BITS-1:0] DEPTH_CNT = CNT_BITS'(DEPTH);
    localparam logic [PTR_BITS-1:0] LAST_PTR = PTR_BITS'(DEPTH - 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_BITS-1:0] wr_ptr;
        logic [PTR_BITS-1:0] rd_ptr;
        logic [CNT_BITS-1:0] count;
        logic has_space;
        logic has_data;
    } rrs_fifo_st_t;

    rrs_fifo_st_t q_r;
    rrs_fifo_st_t q_nxt;
    logic push;
    logic pop;

    assign in_ready = q_r.has_space;
    assign out_valid = q_r.has_data;
    assign out_data = q_r.mem[q_r.rd_ptr];

    always_comb begin
        q_nxt = q_r;
        push = in_valid && q_r.has_space;
        pop = out_ready && q_r.has_data;
        if (push) begin
            q_nxt.mem[q_r.wr_ptr] = in_data;
            q_nxt.wr_ptr = (q_r.wr_ptr == LAST_PTR) ? '0
                : q_r.wr_ptr + 1'b1;
        end
        if (pop) begin
            q_nxt.rd_ptr = (q_r.rd_ptr == LAST_PTR) ? '0
                : q_r.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            q_nxt.count = q_r.count + 1'b1;
        end else if (pop && !push) begin
            q_nxt.count = q_r.count - 1'b1;
        end
        // Flags are kept as flops so the ready port has no logic behind it
        q_nxt.has_space = (q_nxt.count != DEPTH_CNT);
        q_nxt.has_data = (q_nxt.count != '0);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            q_r <= '0;
            q_r.has_space <= 1'b1;
        end else begin
            q_r <= q_nxt;
        end
    end
endmodule

//--- rtl/rrs_chan_rx.sv
// Byte assembler and end-of-frame detector for one receive channel.
// Assumes one symbol per bit time from the correlator, via a FIFO.
`timescale 1ns/10ps
module rrs_chan_rx (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic sym_valid,
    output logic sym_take,
    input wire logic sym_good,
    input wire logic sym_bit,
    input wire logic stall,
    input wire logic [rrs_pkg::EOF_LEN_BITS-1:0] eof_len,
    output logic xfer,
    output logic [rrs_pkg::BYTE_BITS-1:0] xfer_data,
    output logic [rrs_pkg::BYTE_BITS-1:0] xfer_mask,
    output logic eof
);
    typedef enum logic {
        RRS_IDLE = 1'b0,
        RRS_FRAME = 1'b1
    } rrs_rx_state_t;

    typedef struct packed {
        rrs_rx_state_t state;
        logic [rrs_pkg::BYTE_BITS-1:0] data;
        logic [rrs_pkg::BYTE_BITS-1:0] mask;
        logic [rrs_pkg::BIT_POS_BITS-1:0] pos;
        logic [rrs_pkg::EOF_LEN_BITS-1:0] gap;
        logic partial;
    } rrs_rx_st_t;

    rrs_rx_st_t q_r;
    rrs_rx_st_t q_nxt;
    logic [rrs_pkg::BYTE_BITS-1:0] d_fill;
    logic [rrs_pkg::BYTE_BITS-1:0] m_fill;

    always_comb begin
        q_nxt = q_r;
        sym_take = sym_valid && !stall;
        xfer = 1'b0;
        eof = 1'b0;
        d_fill = q_r.data;
        m_fill = q_r.mask;
        d_fill[q_r.pos] = sym_bit;  // see RULE_09
        m_fill[q_r.pos] = sym_good;  // see RULE_13
        xfer_data = d_fill;
        xfer_mask = m_fill;
        case (q_r.state)
            RRS_IDLE: begin
                // Only a valid bit opens a frame
                if (sym_take && sym_good) begin  // see RULE_03
                    q_nxt.data = d_fill;
                    q_nxt.mask = m_fill;
                    q_nxt.pos = q_r.pos + 1'b1;
                    q_nxt.partial = 1'b1;
                    q_nxt.gap = '0;
                    q_nxt.state = RRS_FRAME;
                end
            end
            RRS_FRAME: begin
                if (sym_take && !sym_good && q_r.gap == eof_len) begin
                    // Gap exceeded: the closing invalid bit is not kept
                    eof = 1'b1;  // see RULE_03
                    xfer = q_r.partial;  // see RULE_06
                    xfer_data = q_r.data;
                    xfer_mask = q_r.mask;
                    q_nxt = '0;
                end else if (sym_take) begin
                    q_nxt.gap = sym_good ? '0 : q_r.gap + 1'b1;
                    q_nxt.data = d_fill;
                    q_nxt.mask = m_fill;
                    q_nxt.pos = q_r.pos + 1'b1;
                    q_nxt.partial = 1'b1;
                    if (q_r.pos == rrs_pkg::LAST_BIT_POS) begin
                        xfer = 1'b1;  // see RULE_06
                        q_nxt.data = '0;
                        q_nxt.mask = '0;
                        q_nxt.partial = 1'b0;
                    end
                end
            end
            default: begin
                q_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end
endmodule

//--- rtl/rrs_status_regs.sv
// Receive status register bank of a two-channel spread-spectrum receiver.
// Assumes the serial control port hands in one-cycle read/write strobes
// and that each correlator delivers one symbol per bit time.
//
// What this block does
// RULE_01: Status bits 7 to 0: all-valid, flow, eof, full of B, then of A.
// RULE_02: The channel A end-of-frame flag reads 1 while pending, else 0.
// RULE_03: End of frame needs a valid bit first, then the set gap with none.
// RULE_04: Reading the status register clears the pending end-of-frame flags.
// RULE_05: Moving a byte into the channel A data register sets full A.
// RULE_06: A byte moves over when eight bits are in, or at end of frame.
// RULE_07: The full flag reads 1 while a data-full event is pending, else 0.
// RULE_08: The newest channel A byte reads as an 8-bit register of its own.
// RULE_09: The first bit over the air lands in bit 0, later bits fill upward.
// RULE_10: The channel A data register is read-only; writes are ignored.
// RULE_11: New data landing before the last byte was read flags overflow.
// RULE_12: Reading an empty data register flags underflow.
// RULE_13: The validity register has a 1 for every data bit received valid.
// RULE_14: The all-valid flag is set when all eight held bits are valid.
// RULE_15: Channel B flags follow receiver B like channel A's, but no byte read ever clears full B.
// RULE_16: The all-valid flag is a plain indication and raises no event.
`timescale 1ns/10ps
module rrs_status_regs (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rdack,
    input wire logic [rrs_pkg::EOF_LEN_BITS-1:0] eof_len,
    input wire logic sym_a_valid,
    input wire logic sym_a_good,
    input wire logic sym_a_bit,
    output logic sym_a_ready,
    input wire logic sym_b_valid,
    input wire logic sym_b_good,
    input wire logic sym_b_bit,
    output logic sym_b_ready
);
    localparam int NC = rrs_pkg::NUM_CHAN;
    localparam int BB = rrs_pkg::BYTE_BITS;
    localparam int SW = rrs_pkg::SYM_WIDTH;

    typedef struct packed {
        logic [NC-1:0][BB-1:0] data;
        logic [NC-1:0][BB-1:0] mask;
        logic [NC-1:0] full;
        logic [NC-1:0] eof;
        logic [NC-1:0] flow;
        logic [7:0] rdata;
        logic rdack;
    } rrs_regs_t;

    rrs_regs_t q_r;
    rrs_regs_t q_nxt;

    logic [NC-1:0] in_valid;
    logic [NC-1:0] in_ready;
    logic [NC-1:0][SW-1:0] in_sym;
    logic [NC-1:0] f_valid;
    logic [NC-1:0] f_take;
    logic [NC-1:0][SW-1:0] f_sym;
    logic [NC-1:0] stall;
    logic [NC-1:0] xfer;
    logic [NC-1:0] eof_ev;
    logic [NC-1:0][BB-1:0] xfer_data;
    logic [NC-1:0][BB-1:0] xfer_mask;
    logic rd_status;
    logic rd_byte_a;
    logic [7:0] status_val;

    // Writes are accepted and dropped: every register here is read-only
    logic unused_wr;
    assign unused_wr = reg_wr ^ (^reg_wdata);  // see RULE_10

    assign rd_status = reg_rd && (reg_addr == rrs_pkg::ADDR_RX_IRQ_STATUS);
    assign rd_byte_a = reg_rd && (reg_addr == rrs_pkg::ADDR_RX_BYTE_A);

    assign in_valid = {sym_b_valid, sym_a_valid};
    assign in_sym[0] = {sym_a_good, sym_a_bit};
    assign in_sym[1] = {sym_b_good, sym_b_bit};
    assign sym_a_ready = in_ready[0];
    assign sym_b_ready = in_ready[1];

    // Channel A symbols wait while the host reads the data register, so a
    // load and a read never meet in one cycle; the FIFO absorbs the pause.
    assign stall[0] = rd_byte_a;
    assign stall[1] = 1'b0;

    genvar gi;
    generate
        for (gi = 0; gi < NC; gi++) begin : g_chan
            rrs_fifo #(
                .WIDTH(SW),
                .DEPTH(rrs_pkg::SYM_DEPTH)
            ) u_fifo (
                .sys_clk(sys_clk),
                .rst(rst),
                .in_valid(in_valid[gi]),
                .in_ready(in_ready[gi]),
                .in_data(in_sym[gi]),
                .out_valid(f_valid[gi]),
                .out_ready(f_take[gi]),
                .out_data(f_sym[gi])
            );

            rrs_chan_rx u_rx (
                .sys_clk(sys_clk),
                .rst(rst),
                .sym_valid(f_valid[gi]),
                .sym_take(f_take[gi]),
                .sym_good(f_sym[gi][rrs_pkg::SYM_GOOD_POS]),
                .sym_bit(f_sym[gi][rrs_pkg::SYM_BIT_POS]),
                .stall(stall[gi]),
                .eof_len(eof_len),
                .xfer(xfer[gi]),
                .xfer_data(xfer_data[gi]),
                .xfer_mask(xfer_mask[gi]),
                .eof(eof_ev[gi])
            );
        end
    endgenerate

    always_comb begin
        q_nxt = q_r;
        status_val = '0;
        for (int c = 0; c < NC; c++) begin
            // see RULE_01
            status_val[c*rrs_pkg::STAT_CHAN_STRIDE + rrs_pkg::STAT_FULL_POS]
                = q_r.full[c];  // see RULE_07
            status_val[c*rrs_pkg::STAT_CHAN_STRIDE + rrs_pkg::STAT_EOF_POS]
                = q_r.eof[c];  // see RULE_02
            status_val[c*rrs_pkg::STAT_CHAN_STRIDE + rrs_pkg::STAT_FLOW_POS]
                = q_r.flow[c];
            // Level only, never sticky and never an event; see RULE_16
            status_val[c*rrs_pkg::STAT_CHAN_STRIDE
                + rrs_pkg::STAT_ALLVALID_POS]
                = (q_r.mask[c] == rrs_pkg::ALL_BITS_VALID);  // see RULE_14
        end
        for (int c = 0; c < NC; c++) begin
            // Status read clears first; new events below win the same cycle
            if (rd_status) begin
                q_nxt.eof[c] = 1'b0;  // see RULE_04
                q_nxt.flow[c] = 1'b0;
            end
            if (c == 0 && rd_byte_a) begin
                if (!q_r.full[c]) begin
                    q_nxt.flow[c] = 1'b1;  // see RULE_12
                end
                q_nxt.full[c] = 1'b0;
            end
            if (eof_ev[c]) begin
                q_nxt.eof[c] = 1'b1;  // see RULE_15
            end
            if (xfer[c]) begin
                if (q_r.full[c]) begin
                    q_nxt.flow[c] = 1'b1;  // see RULE_11
                end
                q_nxt.data[c] = xfer_data[c];
                q_nxt.mask[c] = xfer_mask[c];  // see RULE_13
                q_nxt.full[c] = 1'b1;  // see RULE_05
            end
        end
        q_nxt.rdack = reg_rd;
        if (!reg_rd) begin
            q_nxt.rdata = q_r.rdata;
        end else if (reg_addr == rrs_pkg::ADDR_RX_IRQ_STATUS) begin
            q_nxt.rdata = status_val;
        end else if (reg_addr == rrs_pkg::ADDR_RX_BYTE_A) begin
            q_nxt.rdata = q_r.data[0];  // see RULE_08
        end else if (reg_addr == rrs_pkg::ADDR_RX_BITVALID_A) begin
            q_nxt.rdata = q_r.mask[0];
        end else begin
            q_nxt.rdata = rrs_pkg::UNMAPPED_READ;
        end
    end

    assign reg_rdata = q_r.rdata;
    assign reg_rdack = q_r.rdack;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end
endmodule

//--- tb/rrs_monitor.sv
// Port-level checks for the receive status register bank.
// Assumes it is bound to every instance of rrs_status_regs.
`timescale 1ns/10ps
module rrs_monitor (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rdack,
    input wire logic sym_a_valid,
    input wire logic sym_b_valid
);
    // Flags are only predictable once both symbol FIFOs have drained
    logic [5:0] quiet_r, quiet_nxt;
    logic calm;
    always_comb begin
        quiet_nxt = quiet_r;
        if (sym_a_valid || sym_b_valid)
            quiet_nxt = 6'h00;
        else if (quiet_r != 6'h3f)
            quiet_nxt = quiet_r + 6'h01;
    end
    always_ff @(posedge sys_clk) begin
        if (rst)
            quiet_r <= 6'h00;
        else
            quiet_r <= quiet_nxt;
    end
    assign calm = quiet_r >= 6'h30;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_rd(logic [7:0] a);
        reg_rd && reg_addr == a && calm;
    endsequence
    a_ack_follows: assert property (reg_rd |=> reg_rdack)
        else $error("read not answered next cycle");
    a_ack_needs_rd: assert property (
        reg_rdack |-> $past(reg_rd)) else $error("answer without read");
    a_write_ignored: assert property (
        reg_wr && !reg_rd |=> !reg_rdack) else $error("write answered");
    a_unmapped_zero: assert property (
        reg_rd && !(reg_addr inside {8'h08, 8'h09, 8'h0a})
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    a_rdata_holds: assert property (
        !reg_rdack |-> $stable(reg_rdata))
        else $error("read data moved without answer");
    a_status_clears: assert property (
        s_rd(8'h08) ##1 s_rd(8'h08) |=> (reg_rdata & 8'h66) == 8'h00)
        else $error("status read did not clear flags");
    a_underflow_flag: assert property (
        s_rd(8'h09) ##1 s_rd(8'h09) ##1 s_rd(8'h08) |=> reg_rdata[2])
        else $error("empty byte read not flagged");
    a_full_clears: assert property (
        s_rd(8'h09) ##1 s_rd(8'h08) |=> !reg_rdata[0])
        else $error("full flag kept after byte read");
endmodule
bind rrs_status_regs rrs_monitor i_rrs_monitor (.sys_clk(sys_clk),
    .rst(rst), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_rdata(reg_rdata), .reg_rdack(reg_rdack),
    .sym_a_valid(sym_a_valid), .sym_b_valid(sym_b_valid));

//--- tb/rrs_sym_src.sv
// Correlator model offering one symbol per handshake.
// Assumes calls start right after a rising edge of sys_clk.
`timescale 1ns/10ps
module rrs_sym_src (
    input wire logic sys_clk,
    input wire logic ready,
    output logic valid,
    output logic good,
    output logic bit_o
);
    initial begin
        valid <= 1'b0;
        good <= 1'b0;
        bit_o <= 1'b0;
    end
    // Holds the symbol until it is taken at an edge with ready high
    task automatic send(input logic g, input logic b);
        valid <= 1'b1;
        good <= g;
        bit_o <= b;
        do @(posedge sys_clk); while (ready !== 1'b1);
    endtask
    // Released lines show the inverse so stale values are never trusted
    task automatic stop();
        valid <= 1'b0;
        good <= ~good;
        bit_o <= ~bit_o;
    endtask
endmodule

//--- tb/test_rrs_status_regs.sv
// Self-checking bench for the receive status register bank.
// Assumes rrs_sym_src feeds both symbol streams.
`timescale 1ns/10ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_count++; \
 $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module test_rrs_status_regs;
    logic sys_clk = 1'b0, rst = 1'b1, reg_rd = 1'b0, reg_wr = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [rrs_pkg::EOF_LEN_BITS-1:0] eof_len = '0;
    logic reg_rdack, sym_a_valid, sym_a_good, sym_a_bit, sym_a_ready;
    logic sym_b_valid, sym_b_good, sym_b_bit, sym_b_ready;
    int err_count = 0, check_count = 0, refused = 0;
    int pos[2] = '{0, 0}, run[2] = '{0, 0};
    logic inf[2] = '{0, 0}, full[2] = '{0, 0};
    logic flow[2] = '{0, 0}, eof[2] = '{0, 0};
    logic [7:0] dat[2] = '{0, 0}, msk[2] = '{0, 0};
    logic [7:0] pd[2] = '{0, 0}, pm[2] = '{0, 0};
    logic [7:0] ans_q[$];
    always #12.5 sys_clk = ~sys_clk;
    rrs_status_regs i_rrs_status_regs (.sys_clk(sys_clk), .rst(rst),
        .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rdack(reg_rdack), .eof_len(eof_len),
        .sym_a_valid(sym_a_valid), .sym_a_good(sym_a_good),
        .sym_a_bit(sym_a_bit), .sym_a_ready(sym_a_ready),
        .sym_b_valid(sym_b_valid), .sym_b_good(sym_b_good),
        .sym_b_bit(sym_b_bit), .sym_b_ready(sym_b_ready));
    rrs_sym_src src_a (.sys_clk(sys_clk), .ready(sym_a_ready),
        .valid(sym_a_valid), .good(sym_a_good), .bit_o(sym_a_bit));
    rrs_sym_src src_b (.sys_clk(sys_clk), .ready(sym_b_ready),
        .valid(sym_b_valid), .good(sym_b_good), .bit_o(sym_b_bit));
    always @(posedge sys_clk) begin
        if (reg_rdack === 1'b1)
            ans_q.push_back(reg_rdata);
        if (sym_a_valid === 1'b1 && sym_a_ready === 1'b0)
            refused++;
    end
    task automatic m_xfer(input int c);
        if (full[c])
            flow[c] = 1'b1;
        full[c] = 1'b1;
        dat[c] = pd[c];
        msk[c] = pm[c];
        pos[c] = 0;
        pd[c] = 8'h00;
        pm[c] = 8'h00;
    endtask
    task automatic m_sym(input int c, input logic g, input logic b);
        if (g) begin
            inf[c] = 1'b1;
            run[c] = 0;
            pd[c][pos[c]] = b;
            pm[c][pos[c]] = 1'b1;
            pos[c]++;
        end else if (inf[c] && run[c] == eof_len) begin
            eof[c] = 1'b1;
            inf[c] = 1'b0;
            run[c] = 0;
            if (pos[c] > 0)
                m_xfer(c);
        end else if (inf[c]) begin
            run[c]++;
            pos[c]++;
        end
        if (pos[c] == 8)
            m_xfer(c);
    endtask
    function automatic logic [7:0] m_rd(input logic [7:0] a);
        logic [7:0] v;
        v = rrs_pkg::UNMAPPED_READ;
        if (a == rrs_pkg::ADDR_RX_IRQ_STATUS) begin
            for (int c = 0; c < 2; c++) begin
                v[4*c +: 4] = {msk[c] == 8'hff, flow[c], eof[c], full[c]};
                flow[c] = 1'b0;
                eof[c] = 1'b0;
            end
        end else if (a == rrs_pkg::ADDR_RX_BYTE_A) begin
            if (!full[0])
                flow[0] = 1'b1;
            full[0] = 1'b0;
            v = dat[0];
        end else if (a == rrs_pkg::ADDR_RX_BITVALID_A) begin
            v = msk[0];
        end
        return v;
    endfunction
    task automatic rdb(input logic [7:0] q[$]);
        logic [7:0] e, got;
        foreach (q[i]) begin
            @(posedge sys_clk);
            reg_rd <= 1'b1;
            reg_addr <= q[i];
        end
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        repeat (3) @(posedge sys_clk);
        `CHK(ans_q.size(), q.size())
        foreach (q[i]) begin
            e = m_rd(q[i]);
            got = ans_q.pop_front();
            `CHK(got, e)
        end
    endtask
    // Invalid symbols carry bit 0 so unfilled positions read as 0
    task automatic frame(input int c, input int n);
        logic g, b;
        for (int i = 0; i < n + eof_len + 1; i++) begin
            g = (i == 0) || (i < n && $urandom_range(0, 3) != 0);
            b = g & 1'($urandom_range(0, 1));
            m_sym(c, g, b);
            if (c == 0)
                src_a.send(g, b);
            else
                src_b.send(g, b);
        end
        if (c == 0)
            src_a.stop();
        else
            src_b.stop();
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        $display("[ERR] %0t watchdog expired", $time);
        test_done();
    end
    initial begin
        logic [7:0] rq[$];
        rq = '{8'h08, 8'h08, 8'h0a, 8'h09, 8'h09, 8'h08, 8'h55};
        void'($urandom(32'hff30));
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        rdb(rq);
        $display("reset read test done");
        for (int t = 0; t < 12; t++) begin
            eof_len <= 3'($urandom_range(0, 7));
            @(posedge sys_clk);
            fork
                frame(0, $urandom_range(1, 12));
                frame(1, $urandom_range(1, 12));
            join
            repeat (52) @(posedge sys_clk);
            reg_wr <= 1'b1;
            reg_addr <= 8'h09;
            reg_wdata <= 8'($urandom);
            @(posedge sys_clk);
            reg_wr <= 1'b0;
            rdb(rq);
            $display("frame test %0d done", t);
        end
        // Byte reads every cycle stall the assembler so the FIFO fills
        rq = {};
        repeat (44) rq.push_back(8'h09);
        fork
            rdb(rq);
            begin
                repeat (38) src_a.send(1'b0, 1'b0);
                src_a.stop();
            end
        join
        repeat (60) @(posedge sys_clk);
        `CHK(refused > 0, 1'b1)
        `CHK(sym_a_ready, 1'b1)
        `CHK(sym_b_ready, 1'b1)
        $display("fifo test done");
        test_done();
    end
endmodule
